// >>> logic/pmc_device.sv
// pmc_device: power-mode state, clock divider, module halt gating, standby wake
// assumes: cpu-side end drives the link; reset_pin_n and wdt_ovf synchronous
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
// Functional notes
// - nonzero divider moves bus masters at cycle end
// - access length counted in bus-master states
// - zero divider restores full clock at cycle end
// - sleep without standby bit; divider kept after
// - sleep with standby bit enters standby; divider kept
// - reset pin or watchdog resets, clears divider
// - sleep halts cpu, keeps registers, peripherals run
// - sleep ends on reset or accepted interrupt
// - halt bit stops or restarts peripheral at cycle end
// - halted keeps state except serial and adc reset
// - after reset all halted except transfer engine
// - halted peripheral register access is blocked
// - sleep with all halted also halts bus, ports
// - halt bit positions map to named peripherals
// - transfer-engine halt refused while engine active
// - software disables interrupts before halting modules
// - standby stops cpu, peripherals, oscillator; resets serial, adc
// - external wake restarts oscillator, waits, then runs
// - standby wake needs enabled, unmasked, non-transfer request
// - reset pin in standby restarts clocks at once
// - wake wait select gives fixed state counts
// - software picks wake wait long enough for crystal
// - divider codes: full, then divide by 2 to 32
// - standby bus outputs held or floated by hold bit
module pmc_device import pmc_pkg::*; #(
   parameter int unsigned WAIT0 = WAIT_BASE,
   // each longer wait doubles the one before, so one override scales them all
   parameter int unsigned WAIT1 = WAIT0 * 2,
   parameter int unsigned WAIT2 = WAIT0 * 4,
   parameter int unsigned WAIT3 = WAIT0 * 8,
   parameter int unsigned WAIT4 = WAIT0 * 16,
   parameter int unsigned WAIT5 = WAIT0 * 32
) (
   input wire logic pclk,
   input wire logic presetn,
   pmc_if.dev link,
   input wire logic reset_pin_n,
   input wire logic wdt_ovf,
   input wire logic xfer_active,
   input wire logic [15:0] acc_req,
   output logic cpu_run,
   output logic osc_run,
   output logic bm_tick,
   output logic [6:0] acc_len_mem,
   output logic [6:0] acc_len_io,
   output logic [15:0] periph_stop,
   output logic [15:0] periph_rst,
   output logic [15:0] acc_ok,
   output logic bus_ctrl_halt,
   output logic bus_float,
   output logic in_reset
);
   // only these halt bits gate a peripheral; the rest are plain storage
   localparam logic [15:0] USED = (16'h0001 << HB_XFER) | (16'h0001 << HB_PTIM) |
      (16'h0001 << HB_TMR8) | (16'h0001 << HB_DAC) | (16'h0001 << HB_ADC) |
      (16'h0001 << HB_SER2) | (16'h0001 << HB_SER1) | (16'h0001 << HB_SER0);
   localparam logic [15:0] RSTMASK = (16'h0001 << HB_ADC) | (16'h0001 << HB_SER2) |
      (16'h0001 << HB_SER1) | (16'h0001 << HB_SER0);

   logic sys_rst;
   logic [2:0] cur_div;
   logic [18:0] wcnt;
   logic [18:0] next_wcnt;
   pmc_mode_t next_mode;
   logic [15:0] next_stop;
   logic [7:0] wr_h;

   // reserved codes fall back to full clock
   function automatic logic [2:0] div_code(input logic [2:0] sel);
      div_code = (sel > 3'h5) ? 3'h0 : sel;
   endfunction

   // reserved wait code 110 takes the base wait, the same as code 000
   function automatic logic [18:0] wait_len(input logic [2:0] sel);
      unique case (sel)
         3'h0: wait_len = 19'(WAIT0);
         3'h1: wait_len = 19'(WAIT1);
         3'h2: wait_len = 19'(WAIT2);
         3'h3: wait_len = 19'(WAIT3);
         3'h4: wait_len = 19'(WAIT4);
         3'h5: wait_len = 19'(WAIT5);
         3'h6: wait_len = 19'(WAIT0);
         3'h7: wait_len = 19'(WAIT_SHORT);
      endcase
   endfunction

   assign sys_rst = !reset_pin_n || wdt_ovf;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.standby_control <= HW_STANDBY_PIN_RST;
      end else if (sys_rst) begin
         link.standby_control <= HW_STANDBY_PIN_RST;
      end else if (link.reg_wr && link.reg_sel == SEL_HW_STANDBY_PIN) begin
         link.standby_control <= link.reg_wdata & HW_STANDBY_PIN_WMASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.system_clock_control <= SCK_RST;
      end else if (sys_rst) begin
         link.system_clock_control <= SCK_RST;
      end else if (link.reg_wr && link.reg_sel == SEL_SCK) begin
         link.system_clock_control <= link.reg_wdata & SCK_WMASK;
      end
   end

   // the transfer-engine halt bit cannot be set while the engine works
   always_comb begin
      wr_h = link.reg_wdata;
      if (xfer_active && !link.halt[HB_XFER]) begin
         wr_h[HB_XFER-8] = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.halt <= HALT_RST;
      end else if (sys_rst) begin
         link.halt <= HALT_RST;
      end else if (link.reg_wr && link.reg_sel == SEL_HALTH) begin
         link.halt[15:8] <= wr_h;
      end else if (link.reg_wr && link.reg_sel == SEL_HALTL) begin
         link.halt[7:0] <= link.reg_wdata;
      end
   end

   // divider takes effect only between bus cycles, so no access is cut short
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_div <= 3'h0;
      end else if (sys_rst) begin
         cur_div <= 3'h0;
      end else if (link.bus_end) begin
         cur_div <= div_code(link.system_clock_control[SCK_DIV_LSB +: 3]);
      end
   end

   always_comb begin
      next_mode = link.mode;
      next_wcnt = wcnt;
      unique case (link.mode)
         PMC_RUN: begin
            if (link.sleep_req) begin
               next_mode = link.standby_control[SBY_SLEEP_BIT] ? PMC_HW_STANDBY_PIN : PMC_SLEEP;
            end
         end
         PMC_SLEEP: begin
            if (link.int_wake) begin
               next_mode = PMC_RUN;
            end
         end
         PMC_HW_STANDBY_PIN: begin
            if (link.ext_wake) begin
               next_mode = PMC_WAKE;
               next_wcnt = wait_len(link.standby_control[SBY_WAIT_LSB +: 3]);
            end
         end
         PMC_WAKE: begin
            next_wcnt = wcnt - 19'h00001;
            if (wcnt <= 19'h00001) begin
               next_mode = PMC_RUN;
            end
         end
      endcase
      if (sys_rst) begin
         next_mode = PMC_RUN;
         next_wcnt = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.mode <= PMC_RUN;
         wcnt <= '0;
      end else begin
         link.mode <= next_mode;
         wcnt <= next_wcnt;
      end
   end

   // halts follow the register at cycle end; standby stops everything
   always_comb begin
      next_stop = periph_stop;
      if (sys_rst) begin
         next_stop = HALT_RST & USED;
      end else if (next_mode == PMC_HW_STANDBY_PIN || next_mode == PMC_WAKE) begin
         next_stop = USED;
      end else if (link.bus_end) begin
         next_stop = link.halt & USED;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         periph_stop <= HALT_RST & USED;
         periph_rst <= HALT_RST & RSTMASK;
         acc_ok <= '0;
      end else begin
         periph_stop <= next_stop;
         periph_rst <= next_stop & RSTMASK;
         acc_ok <= acc_req & ~next_stop;
      end
   end

   // sleep keeps peripherals clocked; the cpu stops and keeps its state, and the bus controller halts too when all modules, or all but TMR8, are halted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_run <= 1'b0;
         osc_run <= 1'b1;
         in_reset <= 1'b1;
         bus_ctrl_halt <= 1'b0;
         bus_float <= 1'b0;
      end else begin
         cpu_run <= next_mode == PMC_RUN && !sys_rst;
         osc_run <= next_mode != PMC_HW_STANDBY_PIN;
         in_reset <= sys_rst;
         bus_ctrl_halt <= next_mode == PMC_SLEEP &&
            (link.halt == HALT_ALL || link.halt == HALT_BUT_TMR8);
         bus_float <= (next_mode == PMC_HW_STANDBY_PIN || next_mode == PMC_WAKE) &&
            !link.standby_control[SBY_HOLD_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_len_mem <= 7'(STATES_MEM);
         acc_len_io <= 7'(STATES_IO);
      end else begin
         acc_len_mem <= 7'(STATES_MEM << cur_div);
         acc_len_io <= 7'(STATES_IO << cur_div);
      end
   end

   // the bus-master enable stops with the oscillator
   pmc_div #(.CW(5)) u_div (
      .pclk(pclk),
      .presetn(presetn),
      .run(next_mode != PMC_HW_STANDBY_PIN && next_mode != PMC_WAKE),
      .div(cur_div),
      .tick(bm_tick)
   );
endmodule // pmc_device

// >>> logic/pmc_pkg.sv
// pmc_pkg: constants and types shared by both ends of the power-mode controller
// assumes: included before the interface and every module
package pmc_pkg;
   // device register select codes on the link
   localparam logic [1:0] SEL_HW_STANDBY_PIN = 2'h0;
   localparam logic [1:0] SEL_SCK = 2'h1;
   localparam logic [1:0] SEL_HALTH = 2'h2;
   localparam logic [1:0] SEL_HALTL = 2'h3;
   // reset values
   localparam logic [7:0] HW_STANDBY_PIN_RST = 8'h08;
   localparam logic [7:0] SCK_RST = 8'h00;
   localparam logic [15:0] HALT_RST = 16'h3fff;
   // writable bit masks (reserved read-only bits stay zero)
   localparam logic [7:0] HW_STANDBY_PIN_WMASK = 8'hf9;
   localparam logic [7:0] SCK_WMASK = 8'hc7;
   // field positions
   localparam int SBY_SLEEP_BIT = 7;
   localparam int SBY_WAIT_LSB = 4;
   localparam int SBY_HOLD_BIT = 3;
   localparam int SCK_DIV_LSB = 0;
   // halt bit positions
   localparam int HB_XFER = 14;
   localparam int HB_PTIM = 13;
   localparam int HB_TMR8 = 12;
   localparam int HB_DAC = 10;
   localparam int HB_ADC = 9;
   localparam int HB_SER2 = 7;
   localparam int HB_SER1 = 6;
   localparam int HB_SER0 = 5;
   localparam logic [15:0] HALT_ALL = 16'hffff;
   localparam logic [15:0] HALT_BUT_TMR8 = 16'hefff;
   // bus access lengths in bus-master states
   localparam int unsigned STATES_MEM = 1;
   localparam int unsigned STATES_IO = 2;
   // wake waits in states
   localparam int unsigned WAIT_BASE = 8192;
   localparam int unsigned WAIT_SHORT = 16;
   // apb offsets of the controller's own registers
   localparam logic [7:0] A_HW_STANDBY_PIN = 8'h00;
   localparam logic [7:0] A_SCK = 8'h04;
   localparam logic [7:0] A_HALTH = 8'h08;
   localparam logic [7:0] A_HALTL = 8'h0c;
   localparam logic [7:0] A_CMD = 8'h10;
   localparam logic [7:0] A_IRQ = 8'h14;
   localparam logic [7:0] A_STAT = 8'h18;
   typedef enum logic [3:0] {
      PMC_RUN = 4'b0001,
      PMC_SLEEP = 4'b0010,
      PMC_HW_STANDBY_PIN = 4'b0100,
      PMC_WAKE = 4'b1000
   } pmc_mode_t;
endpackage

// >>> logic/pmc_if.sv
// pmc_if: link between the cpu-side end and the power-mode device
// assumes: both ends on the same pclk
`timescale 1ns/10ps
interface pmc_if;
   import pmc_pkg::*;
   logic reg_wr;
   logic [1:0] reg_sel;
   logic [7:0] reg_wdata;
   logic sleep_req;
   logic bus_end;
   logic int_wake;
   logic ext_wake;
   logic [7:0] standby_control;
   logic [7:0] system_clock_control;
   logic [15:0] halt;
   pmc_mode_t mode;
   modport dev (input reg_wr, reg_sel, reg_wdata, sleep_req, bus_end, int_wake,
      ext_wake, output standby_control, system_clock_control, halt, mode);
   modport cpu (output reg_wr, reg_sel, reg_wdata, sleep_req, bus_end, int_wake,
      ext_wake, input standby_control, system_clock_control, halt, mode);
endinterface

// >>> logic/pmc_div.sv
// pmc_div: bus-master clock enable, one pulse every 2**div pclk cycles
// assumes: div already limited to the legal range
`timescale 1ns/10ps
module pmc_div #(
   parameter int CW = 5
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic [2:0] div,
   output logic tick
);
   logic [CW-1:0] cnt;
   logic [CW-1:0] last;
   assign last = CW'((1 << div) - 1);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= '0;
         tick <= 1'b0;
      end else if (!run) begin
         cnt <= '0;
         tick <= 1'b0;
      end else begin
         tick <= (cnt >= last);
         cnt <= (cnt >= last) ? '0 : cnt + 1'b1;
      end
   end
endmodule // pmc_div

// >>> logic/pmc_cpu_end.sv
// pmc_cpu_end: apb slave that forwards register writes, sleep and wake requests
// assumes: apb master on pclk; nmi and irq synchronous, active high
`timescale 1ns/10ps
module pmc_cpu_end import pmc_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic nmi,
   input wire logic [2:0] irq,
   pmc_if.cpu link
);
   logic [2:0] irq_en;
   logic [2:0] irq_xfer;
   logic irq_mask;
   logic acc;

   function automatic logic known(input logic [7:0] a);
      known = a == A_HW_STANDBY_PIN || a == A_SCK || a == A_HALTH || a == A_HALTL ||
         a == A_CMD || a == A_IRQ || a == A_STAT;
   endfunction

   assign acc = psel && penable && pready;

   // zero wait states: data is prepared in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= 1'b1;
         if (psel && !penable) begin
            pslverr <= !known(paddr);
            unique case (paddr)
               A_HW_STANDBY_PIN: prdata <= {24'h000000, link.standby_control};
               A_SCK: prdata <= {24'h000000, link.system_clock_control};
               A_HALTH: prdata <= {24'h000000, link.halt[15:8]};
               A_HALTL: prdata <= {24'h000000, link.halt[7:0]};
               A_IRQ: prdata <= {23'h000000, irq_mask, 1'b0, irq_xfer, 1'b0, irq_en};
               A_STAT: prdata <= {28'h0000000, link.mode};
               default: prdata <= '0;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en <= '0;
         irq_xfer <= '0;
         irq_mask <= 1'b1;
      end else if (acc && pwrite && paddr == A_IRQ) begin
         irq_en <= pwdata[2:0];
         irq_xfer <= pwdata[6:4];
         irq_mask <= pwdata[8];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.reg_wr <= 1'b0;
         link.reg_sel <= SEL_HW_STANDBY_PIN;
         link.reg_wdata <= '0;
         link.sleep_req <= 1'b0;
         link.bus_end <= 1'b1;
         link.int_wake <= 1'b0;
         link.ext_wake <= 1'b0;
      end else begin
         link.reg_wr <= acc && pwrite && paddr[7:4] == 4'h0;
         link.reg_sel <= paddr[3:2];
         link.reg_wdata <= pwdata[7:0];
         link.sleep_req <= acc && pwrite && paddr == A_CMD && pwdata[0];
         link.bus_end <= !(psel && !penable);
         link.int_wake <= nmi || (!irq_mask && |(irq & irq_en));
         link.ext_wake <= nmi || (!irq_mask && |(irq & irq_en & ~irq_xfer));
      end
   end
endmodule // pmc_cpu_end

// >>> sim/pmc_checker.sv
// pmc_checker: link checks between the cpu end and the device
// assumes: instantiated beside the link in the bench, one clock domain
`timescale 1ns/10ps
module pmc_checker import pmc_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic reg_wr,
   input wire logic [1:0] reg_sel,
   input wire logic [7:0] reg_wdata,
   input wire logic sleep_req,
   input wire logic int_wake,
   input wire logic ext_wake,
   input wire logic [7:0] standby_control,
   input wire logic [7:0] system_clock_control,
   input wire logic [15:0] halt,
   input wire pmc_mode_t mode
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_sleep_enter: assert property (sleep_req && mode == PMC_RUN
      && !standby_control[SBY_SLEEP_BIT] |=> mode == PMC_SLEEP) else $error("sleep not entered");
   a_hw_standby_pin_enter: assert property (sleep_req && mode == PMC_RUN
      && standby_control[SBY_SLEEP_BIT] |=> mode == PMC_HW_STANDBY_PIN) else $error("standby not entered");
   // a masked request must not end sleep
   a_sleep_stays: assert property (mode == PMC_SLEEP && !int_wake && !ext_wake
      |=> mode == PMC_SLEEP) else $error("sleep left without wake");
   a_sleep_wakes: assert property (mode == PMC_SLEEP && int_wake
      |-> ##[1:2] mode == PMC_RUN) else $error("sleep not ended");
   a_hw_standby_pin_wakes: assert property (mode == PMC_HW_STANDBY_PIN && ext_wake
      |=> mode == PMC_WAKE) else $error("standby wake wait not started");
   a_wake_exit: assert property (mode == PMC_WAKE
      |=> mode == PMC_WAKE || mode == PMC_RUN) else $error("wake wait left wrongly");
   a_sck_write: assert property (reg_wr && reg_sel == SEL_SCK
      |=> system_clock_control == ($past(reg_wdata) & SCK_WMASK)) else $error("divider write lost");
   a_hw_standby_pin_write: assert property (reg_wr && reg_sel == SEL_HW_STANDBY_PIN
      |=> standby_control == ($past(reg_wdata) & HW_STANDBY_PIN_WMASK)) else $error("standby write lost");
   a_halt_low: assert property (reg_wr && reg_sel == SEL_HALTL
      |=> halt[7:0] == $past(reg_wdata)) else $error("halt low write lost");
   // bit 14 may be refused, so only the other high bits are tied to the write
   a_halt_high: assert property (reg_wr && reg_sel == SEL_HALTH
      |=> {halt[15], halt[13:8]} == {$past(reg_wdata[7]), $past(reg_wdata[5:0])})
      else $error("halt high write lost");
endmodule // pmc_checker

// >>> sim/power_mode_controller_tb.sv
// power_mode_controller_tb: apb stimulus to the cpu end, checks at both ends
// assumes: device base wake wait shortened to 4 cycles, longer codes double it
`timescale 1ns/10ps
module power_mode_controller_tb import pmc_pkg::*;;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic nmi = 1'b0, reset_pin_n = 1'b1, wdt_ovf = 1'b0, xfer_active = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic [2:0] irq = 3'h0;
   logic pready, pslverr, rerr, cpu_run, osc_run, bm_tick, bus_ctrl_halt, bus_float, in_reset;
   logic [6:0] acc_len_mem, acc_len_io;
   logic [15:0] periph_stop, periph_rst, acc_ok;
   logic [15:0] acc_req = 16'hffff;
   int n_errors = 0, compares = 0, c, n, k;
   int cnt[8];
   int wt[8] = '{4, 8, 16, 32, 64, 128, 4, 16};
   logic [15:0] hv[3] = '{16'hffff, 16'hefff, 16'h7fff};
   logic bx[3] = '{1'b1, 1'b1, 1'b0};
   pmc_if pmc_if_i ();
   pmc_cpu_end pmc_cpu_end_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .nmi(nmi), .irq(irq), .link(pmc_if_i.cpu));
   // external clock assumed, so the shortest wake wait is fine
   pmc_device #(.WAIT0(4))
      pmc_device_i (.pclk(pclk), .presetn(presetn), .link(pmc_if_i.dev),
      .reset_pin_n(reset_pin_n), .wdt_ovf(wdt_ovf), .xfer_active(xfer_active),
      .acc_req(acc_req), .cpu_run(cpu_run), .osc_run(osc_run), .bm_tick(bm_tick),
      .acc_len_mem(acc_len_mem), .acc_len_io(acc_len_io), .periph_stop(periph_stop),
      .periph_rst(periph_rst), .acc_ok(acc_ok), .bus_ctrl_halt(bus_ctrl_halt),
      .bus_float(bus_float), .in_reset(in_reset));
   pmc_checker pmc_checker_i (.pclk(pclk), .presetn(presetn), .reg_wr(pmc_if_i.reg_wr),
      .reg_sel(pmc_if_i.reg_sel), .reg_wdata(pmc_if_i.reg_wdata),
      .sleep_req(pmc_if_i.sleep_req), .int_wake(pmc_if_i.int_wake),
      .ext_wake(pmc_if_i.ext_wake), .standby_control(pmc_if_i.standby_control), .system_clock_control(pmc_if_i.system_clock_control),
      .halt(pmc_if_i.halt), .mode(pmc_if_i.mode));
   always #20 pclk = ~pclk;
   task automatic tally_and_finish();
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int m);
      repeat (m) @(posedge pclk);
   endtask
   // entered just after a rising edge; an idle edge follows so psel is never rewritten at once
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      if (pready !== 1'b1) begin
         n_errors++;
         $display("Error at %0t: no pready", $time);
         tally_and_finish();
      end
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdata, e);
   endtask
   task automatic wait_run(output int w);
      int t;
      w = 0;
      for (t = 0; t < 300 && pmc_if_i.mode !== PMC_RUN; t++) begin
         @(posedge pclk);
         w += int'(pmc_if_i.mode === PMC_WAKE);
      end
      if (t == 300) begin
         n_errors++;
         $display("Error at %0t: no return to run", $time);
         tally_and_finish();
      end
   endtask
   task automatic nmi_pulse();
      nmi <= 1'b1;
      cyc(1);
      nmi <= 1'b0;
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      cyc(2);
      rd(A_HW_STANDBY_PIN, 32'(HW_STANDBY_PIN_RST));
      rd(A_SCK, 32'(SCK_RST));
      rd(A_HALTH, 32'h3f);
      rd(A_HALTL, 32'hff);
      chk(32'(periph_stop), 32'h36e0);
      chk(32'(periph_rst), 32'h2e0);
      apb(1'b0, 8'h1c, 32'h0);
      chk(32'(rerr), 32'h1);
      $display("reset test done");
      for (int i = 1; i <= 6; i++) begin
         c = i % 6;
         wr(A_SCK, 32'(c));
         cyc(4);
         chk(32'(acc_len_mem), 32'h1 << c);
         chk(32'(acc_len_io), 32'h2 << c);
         n = 0;
         repeat (64) begin
            @(posedge pclk);
            n += int'(bm_tick);
         end
         chk(32'(n), 32'h40 >> c);
      end
      $display("divider test done");
      wr(A_IRQ, 32'h100);
      wr(A_HALTH, 32'hff);
      wr(A_HALTL, 32'hff);
      cyc(3);
      chk(32'(periph_stop), 32'h76e0);
      chk(32'(acc_ok), 32'h891f);
      acc_req <= 16'h00f0;
      cyc(2);
      chk(32'(acc_ok), 32'h10);
      acc_req <= 16'hffff;
      chk(32'(periph_rst), 32'h2e0);
      wr(A_HALTH, 32'h0);
      wr(A_HALTL, 32'h0);
      cyc(3);
      chk(32'(periph_stop), 32'h0);
      chk(32'(acc_ok), 32'hffff);
      xfer_active <= 1'b1;
      wr(A_HALTH, 32'h40);
      rd(A_HALTH, 32'h0);
      xfer_active <= 1'b0;
      $display("halt test done");
      wr(A_SCK, 32'h2);
      foreach (hv[i]) begin
         wr(A_HALTH, 32'(hv[i][15:8]));
         wr(A_HALTL, 32'(hv[i][7:0]));
         wr(A_HW_STANDBY_PIN, 32'h0);
         wr(A_CMD, 32'h1);
         cyc(3);
         chk(32'(pmc_if_i.mode), 32'(PMC_SLEEP));
         chk(32'(cpu_run), 32'h0);
         chk(32'(bus_ctrl_halt), 32'(bx[i]));
         irq <= 3'h7;
         cyc(4);
         chk(32'(pmc_if_i.mode), 32'(PMC_SLEEP));
         irq <= 3'h0;
         nmi_pulse();
         cyc(4);
         chk(32'(pmc_if_i.mode), 32'(PMC_RUN));
         chk(32'(acc_len_mem), 32'h4);
      end
      wr(A_HALTH, 32'h0);
      wr(A_HALTL, 32'h0);
      $display("sleep test done");
      wr(A_IRQ, 32'h1);
      foreach (wt[i]) begin
         if (i != 6) begin
            wr(A_HW_STANDBY_PIN, 32'h80 | (32'(i) << 4));
            wr(A_CMD, 32'h1);
            cyc(3);
            chk(32'(pmc_if_i.mode), 32'(PMC_HW_STANDBY_PIN));
            chk(32'(osc_run), 32'h0);
            chk(32'(periph_rst), 32'h2e0);
            chk(32'(bus_float), 32'h1);
            irq <= 3'h1;
            wait_run(cnt[i]);
            irq <= 3'h0;
            cyc(2);
            chk(32'(acc_len_mem), 32'h4);
         end
      end
      foreach (wt[i]) begin
         if (i != 6) chk(32'(cnt[i] - cnt[0]), 32'(wt[i] - wt[0]));
      end
      // irq 0 routed to the transfer engine must not end standby
      wr(A_IRQ, 32'h11);
      wr(A_CMD, 32'h1);
      irq <= 3'h1;
      cyc(8);
      chk(32'(pmc_if_i.mode), 32'(PMC_HW_STANDBY_PIN));
      irq <= 3'h0;
      nmi_pulse();
      wait_run(k);
      $display("standby test done");
      wr(A_CMD, 32'h1);
      cyc(3);
      reset_pin_n <= 1'b0;
      cyc(3);
      chk(32'(osc_run), 32'h1);
      chk(32'(in_reset), 32'h1);
      reset_pin_n <= 1'b1;
      cyc(3);
      rd(A_SCK, 32'h0);
      chk(32'(acc_len_mem), 32'h1);
      wr(A_SCK, 32'h3);
      wdt_ovf <= 1'b1;
      cyc(1);
      wdt_ovf <= 1'b0;
      cyc(2);
      rd(A_SCK, 32'h0);
      $display("reset pin test done");
      tally_and_finish();
   end
endmodule // power_mode_controller_tb
